// ===== core/i2cmm_ctrl.sv
// I2C multimaster controller with Avalon-MM register access
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
// Overview of operation
// RL1: Clearing enable stops all transfers and releases both lines.
// RL2: Moves 8-bit units over one clock and one data line, multimaster.
// RL3: Master generates start, address, direction, data, stop; slave decodes them in hardware.
// RL4: Both lines are open-drain: pull low or release, pull-ups give high.
// RL5: Shift register serialises transmit bytes and collects received bits.
// RL6: Shift register writes start transfers; eight bits, resets to zero.
// RL7: Own address register holds slave address; eight bits, resets to zero.
// RL8: Data latch holds the level driven onto the data line.
// RL9: Interrupt on own address match or extension code reception.
// RL10: Bit counter counts generated and received clocks to frame bytes.
// RL11: Interrupt at falling edge of eighth or ninth clock per timing select.
// RL12: Stop detection raises interrupt when stop interrupt enable is set.
// RL13: Master clock comes from a prescaler-selected sampling rate.
// RL14: Data changes only after a hold time following each clock fall.
// RL15: Start request generates a start condition.
// RL16: With reservation disabled and bus busy, start is ignored and fail flag set.
// RL17: Stop request generates a stop condition.
// RL18: Busy tracked by start and stop; initial value from select bit.
// RL19: Wait controller holds clock low at the wait point until released.
// RL20: Generates acknowledges and detects acknowledge, start and stop.
// RL21: Enabling with clock high and data low detects start; software then exits.
// RL22: Disabling clears status, start fail, busy and line level flags.
// RL23: One clock, synchronised line inputs, reset returns registers to reset values.
module i2cmm_ctrl #(
    parameter int HOLD_CYCLES = i2cmm_pkg::HOLD_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [i2cmm_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Bus lines
    input wire logic bus_clock_pin_i,
    output logic bus_clock_pin_o,
    output logic bus_clock_pin_oe,
    input wire logic bus_data_pin_i,
    output logic bus_data_pin_o,
    output logic bus_data_pin_oe,
    // Bus event
    output logic bus_event_irq
);
    logic ack_reg, enable_reg, spie_reg, wtim_reg, acke_reg, rsv_dis_reg, init_free_reg;
    logic [i2cmm_pkg::PRESC_W-1:0] presc_sel_reg;
    logic [7:0] own_slave_address_reg, bus_shift_register_reg, presc_cnt_reg;
    i2cmm_pkg::i2cmm_lines_s line_s1_reg, line_s2_reg, line_prev_reg;
    i2cmm_pkg::i2cmm_status_s bus_status_register_reg;
    i2cmm_pkg::i2cmm_mst_e mst_state;
    logic busy_reg, start_fail_reg, start_pend_reg, stop_pend_reg;
    logic engaged_reg, addr_phase_reg, wait_reg, sdo_reg, irq_reg;
    logic [3:0] bit_cnt_reg;
    logic [i2cmm_pkg::HOLD_W-1:0] hold_cnt_reg;
    logic [7:0] rd_byte;
    logic wr_fire, ctrl_wr, shift_wr, start_wr, stop_wr, exit_wr, wrel_wr, quiet;
    logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond, tick, tx_now;
    logic addr_match, ext_code, addr_hit, ev8, ev9, frame_irq, mst_active, scl_low, sda_force;

    // Avalon access completes one cycle after it is presented
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_fire = avs_write & ack_reg;
    assign ctrl_wr = wr_fire && (avs_address == i2cmm_pkg::OFS_CTRL);
    assign shift_wr = wr_fire && (avs_address == i2cmm_pkg::OFS_SHIFT) && enable_reg;
    assign start_wr = ctrl_wr && avs_writedata[i2cmm_pkg::CTL_START] && enable_reg;
    assign stop_wr = ctrl_wr && avs_writedata[i2cmm_pkg::CTL_STOP] && enable_reg;
    assign exit_wr = ctrl_wr && avs_writedata[i2cmm_pkg::CTL_EXIT] && enable_reg;
    assign wrel_wr = ctrl_wr && avs_writedata[i2cmm_pkg::CTL_WREL] && enable_reg;
    assign quiet = ~enable_reg | exit_wr;

    always_comb begin
        unique case (avs_address)
            i2cmm_pkg::OFS_CTRL: rd_byte = {enable_reg, 2'b00, spie_reg, wtim_reg, acke_reg,
                start_pend_reg, stop_pend_reg};
            i2cmm_pkg::OFS_STATUS: rd_byte = bus_status_register_reg;
            i2cmm_pkg::OFS_FLAG: rd_byte = {start_fail_reg, busy_reg, 4'h0, init_free_reg,
                rsv_dis_reg};
            i2cmm_pkg::OFS_CLKSEL: rd_byte = {2'b00, scl_s & enable_reg, sda_s & enable_reg,
                2'b00, presc_sel_reg};
            i2cmm_pkg::OFS_SHIFT: rd_byte = bus_shift_register_reg;
            i2cmm_pkg::OFS_OWN: rd_byte = own_slave_address_reg;
            default: rd_byte = i2cmm_pkg::RD_UNMAPPED[7:0];
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            avs_readdata <= i2cmm_pkg::RD_UNMAPPED;
        end else if (clk_en) begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if ((avs_read | avs_write) & ~ack_reg) begin
                avs_readdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // RL7 own address storage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= 1'b0;
            spie_reg <= 1'b0;
            wtim_reg <= 1'b0;
            acke_reg <= 1'b0;
            rsv_dis_reg <= 1'b0;
            init_free_reg <= 1'b0;
            presc_sel_reg <= '0;
            own_slave_address_reg <= i2cmm_pkg::OWN_ADDR_RST;
        end else if (clk_en && wr_fire) begin
            if (avs_address == i2cmm_pkg::OFS_CTRL) begin
                enable_reg <= avs_writedata[i2cmm_pkg::CTL_ENABLE];
                spie_reg <= avs_writedata[i2cmm_pkg::CTL_SPIE];
                wtim_reg <= avs_writedata[i2cmm_pkg::CTL_WTIM];
                acke_reg <= avs_writedata[i2cmm_pkg::CTL_ACKE];
            end
            if (avs_address == i2cmm_pkg::OFS_FLAG) begin
                rsv_dis_reg <= avs_writedata[i2cmm_pkg::FLG_RSV_DIS];
                init_free_reg <= avs_writedata[i2cmm_pkg::FLG_INIT_FREE];
            end
            if (avs_address == i2cmm_pkg::OFS_CLKSEL) begin
                presc_sel_reg <= avs_writedata[i2cmm_pkg::PRESC_W-1:0];
            end
            if (avs_address == i2cmm_pkg::OFS_OWN) begin
                own_slave_address_reg <= avs_writedata[7:0];
            end
        end
    end

    // RL23 two-stage line synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_s1_reg <= '1;
            line_s2_reg <= '1;
            line_prev_reg <= '1;
        end else if (clk_en) begin
            line_s1_reg <= {bus_clock_pin_i, bus_data_pin_i};
            line_s2_reg <= line_s1_reg;
            // RL21 lines idle high while off, so a low data line is a start on enable
            line_prev_reg <= enable_reg ? line_s2_reg : '1;
        end
    end

    assign scl_s = line_s2_reg.clk;
    assign sda_s = line_s2_reg.dat;
    assign scl_rise = enable_reg & scl_s & ~line_prev_reg.clk;
    assign scl_fall = enable_reg & ~scl_s & line_prev_reg.clk;
    // RL20 start and stop detectors
    assign start_cond = enable_reg & scl_s & line_prev_reg.clk & line_prev_reg.dat & ~sda_s;
    assign stop_cond = enable_reg & scl_s & line_prev_reg.clk & ~line_prev_reg.dat & sda_s;

    // RL13 sampling clock prescaler
    assign tick = enable_reg && (presc_cnt_reg == 8'h00);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_cnt_reg <= 8'h00;
        end else if (clk_en) begin
            if (!enable_reg || tick) begin
                presc_cnt_reg <= i2cmm_pkg::PRESC_HALF[presc_sel_reg * 8 +: 8] - 8'h01;
            end else begin
                presc_cnt_reg <= presc_cnt_reg - 8'h01;
            end
        end
    end

    // RL9 address compare and extension codes
    assign addr_match = bus_shift_register_reg[7:1] == own_slave_address_reg[7:1];
    assign ext_code = (bus_shift_register_reg[7:4] == i2cmm_pkg::EXT_CODE_LO) ||
        (bus_shift_register_reg[7:4] == i2cmm_pkg::EXT_CODE_HI);
    assign mst_active = mst_state != i2cmm_pkg::MS_IDLE;
    assign ev8 = scl_fall && (bit_cnt_reg == i2cmm_pkg::BIT_LAST_DATA);
    assign ev9 = scl_fall && (bit_cnt_reg == i2cmm_pkg::BIT_ACK_DONE);
    assign addr_hit = ev8 & addr_phase_reg & ~mst_active & (addr_match | ext_code);
    assign tx_now = bus_status_register_reg.transmit;

    // RL2 RL3 RL5 RL10 byte engine shared by master and slave
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_status_register_reg <= '0;
            bit_cnt_reg <= 4'h0;
            addr_phase_reg <= 1'b0;
            engaged_reg <= 1'b0;
            bus_shift_register_reg <= i2cmm_pkg::SHIFT_RST;
        end else if (clk_en) begin
            bus_status_register_reg.master <= mst_active;
            if (quiet) begin
                // RL22 status cleared while off
                bus_status_register_reg <= '0;
                bit_cnt_reg <= 4'h0;
                addr_phase_reg <= 1'b0;
                engaged_reg <= 1'b0;
            end else if (start_cond) begin
                bus_status_register_reg <= '0;
                bus_status_register_reg.start_seen <= 1'b1;
                bus_status_register_reg.transmit <= mst_state == i2cmm_pkg::MS_START;
                engaged_reg <= mst_state == i2cmm_pkg::MS_START;
                bit_cnt_reg <= 4'h0;
                addr_phase_reg <= 1'b1;
            end else if (stop_cond) begin
                bus_status_register_reg <= '0;
                bus_status_register_reg.stop_seen <= 1'b1;
                engaged_reg <= 1'b0;
                addr_phase_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
            end else if (scl_rise) begin
                if (bit_cnt_reg < i2cmm_pkg::BIT_LAST_DATA) begin
                    // RL6 received bits land in the shift register
                    bus_shift_register_reg <= {bus_shift_register_reg[6:0], sda_s};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (mst_active && tx_now && sdo_reg && !sda_s) begin
                        bus_status_register_reg.arb_lost <= 1'b1;
                        engaged_reg <= 1'b0;
                    end
                end else begin
                    // RL20 acknowledge detection
                    bus_status_register_reg.ack_seen <= ~sda_s;
                    bit_cnt_reg <= i2cmm_pkg::BIT_ACK_DONE;
                end
            end else if (ev8 && addr_phase_reg) begin
                if (mst_active) begin
                    bus_status_register_reg.transmit <= ~bus_shift_register_reg[0];
                end else if (addr_match || ext_code) begin
                    engaged_reg <= 1'b1;
                    bus_status_register_reg.addr_match <= addr_match;
                    bus_status_register_reg.ext_code <= ext_code;
                    bus_status_register_reg.transmit <= bus_shift_register_reg[0];
                end
            end else if (ev9) begin
                bit_cnt_reg <= 4'h0;
                addr_phase_reg <= 1'b0;
            end else if (shift_wr) begin
                bus_shift_register_reg <= avs_writedata[7:0];
            end
        end
    end

    // RL11 RL12 interrupt and wait point
    assign frame_irq = engaged_reg & ((ev8 & ~wtim_reg) | (ev9 & wtim_reg));
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
            wait_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= ~quiet & (frame_irq | addr_hit | (stop_cond & spie_reg));
            // RL19 wait held until released by software, a stop condition or disable
            // A new wait point beats a software release in the same cycle
            if (quiet || stop_cond) begin
                wait_reg <= 1'b0;
            end else if (frame_irq || addr_hit ||
                    (mst_state == i2cmm_pkg::MS_START && tick)) begin
                wait_reg <= 1'b1;
            end else if (wrel_wr || shift_wr || start_wr || stop_wr) begin
                wait_reg <= 1'b0;
            end
        end
    end
    assign bus_event_irq = irq_reg;

    // RL14 hold counter after each clock fall
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt_reg <= '0;
        end else if (clk_en) begin
            if (scl_fall) begin
                hold_cnt_reg <= i2cmm_pkg::HOLD_W'(HOLD_CYCLES);
            end else if (hold_cnt_reg != '0) begin
                hold_cnt_reg <= hold_cnt_reg - 1'b1;
            end
        end
    end

    // RL8 data output latch
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdo_reg <= 1'b1;
        end else if (clk_en) begin
            if (quiet || stop_cond) begin
                sdo_reg <= 1'b1;
            end else if (shift_wr) begin
                sdo_reg <= tx_now ? avs_writedata[7] : 1'b1;
            end else if (hold_cnt_reg == i2cmm_pkg::HOLD_W'(1)) begin
                if (bit_cnt_reg == i2cmm_pkg::BIT_LAST_DATA) begin
                    // RL20 acknowledge drive in the ninth bit
                    sdo_reg <= ~(engaged_reg & acke_reg & (addr_phase_reg ? ~mst_active : ~tx_now));
                end else begin
                    sdo_reg <= (tx_now & engaged_reg) ? bus_shift_register_reg[7] : 1'b1;
                end
            end
        end
    end

    // RL16 RL18 busy tracking and start bookkeeping
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= 1'b0;
            start_fail_reg <= 1'b0;
            start_pend_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (!enable_reg) begin
                busy_reg <= ctrl_wr ? ~init_free_reg : 1'b0;
                start_fail_reg <= 1'b0;
                start_pend_reg <= 1'b0;
                stop_pend_reg <= 1'b0;
            end else begin
                if (start_cond) begin
                    busy_reg <= 1'b1;
                end else if (stop_cond) begin
                    busy_reg <= 1'b0;
                end
                if (start_wr && rsv_dis_reg && busy_reg && !mst_active) begin
                    start_fail_reg <= 1'b1;
                end else if (start_wr) begin
                    start_pend_reg <= 1'b1;
                end else if (mst_state == i2cmm_pkg::MS_START || exit_wr) begin
                    start_pend_reg <= 1'b0;
                end
                if (stop_wr && mst_active) begin
                    stop_pend_reg <= 1'b1;
                end else if (mst_state == i2cmm_pkg::MS_STOP_LOW || !mst_active) begin
                    stop_pend_reg <= 1'b0;
                end
            end
        end
    end

    // RL15 RL17 master clock, start and stop generation
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mst_state <= i2cmm_pkg::MS_IDLE;
        end else if (clk_en) begin
            if (quiet || bus_status_register_reg.arb_lost) begin
                mst_state <= i2cmm_pkg::MS_IDLE;
            end else begin
                unique case (mst_state)
                    i2cmm_pkg::MS_IDLE: if (start_pend_reg && !busy_reg && scl_s && sda_s) begin
                        mst_state <= i2cmm_pkg::MS_START;
                    end
                    i2cmm_pkg::MS_START: if (tick) begin
                        mst_state <= i2cmm_pkg::MS_LOW;
                    end
                    i2cmm_pkg::MS_LOW: if (stop_pend_reg) begin
                        mst_state <= i2cmm_pkg::MS_STOP_LOW;
                    end else if (start_pend_reg) begin
                        mst_state <= i2cmm_pkg::MS_RS_LOW;
                    end else if (tick && !wait_reg && hold_cnt_reg == '0) begin
                        mst_state <= i2cmm_pkg::MS_HIGH;
                    end
                    i2cmm_pkg::MS_HIGH: if (tick && scl_s) begin
                        mst_state <= i2cmm_pkg::MS_LOW;
                    end
                    i2cmm_pkg::MS_RS_LOW: if (tick) begin
                        mst_state <= i2cmm_pkg::MS_RS_HIGH;
                    end
                    i2cmm_pkg::MS_RS_HIGH: if (tick && scl_s) begin
                        mst_state <= i2cmm_pkg::MS_START;
                    end
                    i2cmm_pkg::MS_STOP_LOW: if (tick) begin
                        mst_state <= i2cmm_pkg::MS_STOP_HIGH;
                    end
                    i2cmm_pkg::MS_STOP_HIGH: if (tick && scl_s) begin
                        mst_state <= i2cmm_pkg::MS_IDLE;
                    end
                endcase
            end
        end
    end

    assign scl_low = (mst_state == i2cmm_pkg::MS_LOW) || (mst_state == i2cmm_pkg::MS_RS_LOW) ||
        (mst_state == i2cmm_pkg::MS_STOP_LOW);
    assign sda_force = (mst_state == i2cmm_pkg::MS_START) ||
        (mst_state == i2cmm_pkg::MS_STOP_LOW) || (mst_state == i2cmm_pkg::MS_STOP_HIGH);

    // RL1 RL4 open-drain drive, nothing while off
    assign bus_clock_pin_o = 1'b0;
    assign bus_data_pin_o = 1'b0;
    assign bus_clock_pin_oe = enable_reg & (scl_low | wait_reg);
    assign bus_data_pin_oe = enable_reg & (sda_force | (~sdo_reg &
        (mst_state != i2cmm_pkg::MS_RS_LOW) && (mst_state != i2cmm_pkg::MS_RS_HIGH)));

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Inside the hold window, counted from the clock fall
    sequence fall_seen_s;
        clk_en && !quiet && !stop_cond && !shift_wr &&
            ((scl_fall && hold_cnt_reg == '0) || hold_cnt_reg > i2cmm_pkg::HOLD_W'(1));
    endsequence
    sequence held_s;
        $stable(sdo_reg);
    endsequence

    start_fail_a: assert property (clk_en && start_wr && rsv_dis_reg && busy_reg && !mst_active
        |=> start_fail_reg) else $error("start not refused on busy bus"); // RL16
    disable_clr_a: assert property (clk_en && !enable_reg |=> !start_fail_reg &&
        bus_status_register_reg == '0 && !bus_data_pin_oe)
        else $error("disable did not clear state"); // RL22
    addr_irq_a: assert property (clk_en && enable_reg && addr_hit && !exit_wr |=> bus_event_irq
        && engaged_reg) else $error("no event on address hit"); // RL9
    stop_irq_a: assert property (clk_en && stop_cond && spie_reg && !exit_wr |=> bus_event_irq)
        else $error("no event on stop"); // RL12
    hold_time_a: assert property (fall_seen_s |=> held_s)
        else $error("data changed inside hold time"); // RL14
    bit_count_a: assert property (clk_en && enable_reg && !exit_wr && scl_rise &&
        bit_cnt_reg < i2cmm_pkg::BIT_LAST_DATA |=> bit_cnt_reg == $past(bit_cnt_reg) + 4'h1)
        else $error("bit counter did not advance"); // RL10
    frame_wait_a: assert property (clk_en && frame_irq && !quiet && !shift_wr && !wrel_wr |=>
        bus_event_irq && bus_clock_pin_oe) else $error("eighth or ninth clock missed"); // RL11
    wait_low_a: assert property (clk_en && wait_reg && mst_state == i2cmm_pkg::MS_LOW |=>
        mst_state != i2cmm_pkg::MS_HIGH) else $error("clock released during wait"); // RL19
    busy_track_a: assert property (clk_en && enable_reg && start_cond |=> busy_reg)
        else $error("busy not set by start"); // RL18
    stop_gen_a: assert property (clk_en && stop_wr && mst_state == i2cmm_pkg::MS_LOW |-> ##[1:3]
        mst_state == i2cmm_pkg::MS_STOP_LOW) else $error("stop request not served"); // RL17
endmodule : i2cmm_ctrl

// ===== core/i2cmm_pkg.sv
// I2C multimaster controller package: register map, fields, timing and types
package i2cmm_pkg;
    // Byte addresses on the register bus
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_FLAG = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CLKSEL = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_SHIFT = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_OWN = 5'h14;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Control register fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_EXIT = 6;
    localparam int CTL_WREL = 5;
    localparam int CTL_SPIE = 4;
    localparam int CTL_WTIM = 3;
    localparam int CTL_ACKE = 2;
    localparam int CTL_START = 1;
    localparam int CTL_STOP = 0;

    // Flag and clock-select fields
    localparam int FLG_START_FAIL = 7;
    localparam int FLG_BUSY = 6;
    localparam int FLG_INIT_FREE = 1;
    localparam int FLG_RSV_DIS = 0;
    localparam int CLS_CLK_LVL = 5;
    localparam int CLS_DAT_LVL = 4;
    localparam int PRESC_W = 2;

    // Reset values and byte framing
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [3:0] BIT_LAST_DATA = 4'h8;
    localparam logic [3:0] BIT_ACK_DONE = 4'h9;
    localparam logic [3:0] EXT_CODE_LO = 4'h0;
    localparam logic [3:0] EXT_CODE_HI = 4'hf;

    // Timing
    localparam int SYS_CLK_MHZ = 20;
    localparam int HOLD_TIME_NS = 300;
    localparam int HOLD_RAW = (HOLD_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
    localparam int HOLD_W = 4;
    // Half period of the bus clock in core cycles, one byte per prescaler choice
    localparam logic [31:0] PRESC_HALF = 32'hc864_3219;

    typedef struct packed {
        logic clk;
        logic dat;
    } i2cmm_lines_s;

    typedef struct packed {
        logic master;
        logic arb_lost;
        logic ext_code;
        logic addr_match;
        logic transmit;
        logic ack_seen;
        logic start_seen;
        logic stop_seen;
    } i2cmm_status_s;

    typedef enum logic [2:0] {
        MS_IDLE, MS_START, MS_LOW, MS_HIGH, MS_RS_LOW, MS_RS_HIGH, MS_STOP_LOW, MS_STOP_HIGH
    } i2cmm_mst_e;
endpackage : i2cmm_pkg

// ===== verif/i2c_multimaster_controller_bench.sv
// Register-level bench for the I2C multimaster controller
`timescale 1ns/1ns
module i2c_multimaster_controller_bench;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, scl, sda, scl_oe, sda_oe, bus_event_irq;
    logic [7:0] q;
    int n_fail = 0;
    int n_tests = 0;
    int k;
    logic ext_scl_pull = 1'b0;
    logic ext_sda_pull = 1'b0;
    localparam logic [7:0] SLV_BYTE = 8'h5a;
    i2cmm_ctrl #(.HOLD_CYCLES(2)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_clock_pin_i(scl), .bus_clock_pin_o(),
        .bus_clock_pin_oe(scl_oe), .bus_data_pin_i(sda), .bus_data_pin_o(),
        .bus_data_pin_oe(sda_oe), .bus_event_irq(bus_event_irq));
    i2cmm_peer u_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .ext_scl_pull(ext_scl_pull),
        .ext_sda_pull(ext_sda_pull), .scl(scl), .sda(sda));
    initial forever #25 core_clk = ~core_clk;
    task conclude;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // Request held until waitrequest is seen low
    task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        int t;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h00_0000, d};
        for (t = 0; t < 50; t++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (t == 50) begin
            n_fail++;
            conclude();
        end
    endtask : acc
    task rd(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd
    // A wait that uses up its bound ends the run as a failure
    task lim(input int n, input int m);
        if (n >= m) begin
            n_fail++;
            conclude();
        end
    endtask : lim
    // Far-side master levels, one step of ten cycles
    task bb(input logic c, input logic d);
        ext_scl_pull <= !c;
        ext_sda_pull <= !d;
        repeat (10) @(posedge core_clk);
    endtask : bb
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(i2cmm_pkg::OFS_SHIFT, 8'h00);
        rd(i2cmm_pkg::OFS_OWN, 8'h00);
        acc(1'b1, i2cmm_pkg::OFS_OWN, 8'h5a);
        rd(i2cmm_pkg::OFS_OWN, 8'h5a);
        rd(5'h1c, 8'h00);
        acc(1'b1, i2cmm_pkg::OFS_FLAG, 8'h03);
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h88);
        rd(i2cmm_pkg::OFS_FLAG, 8'h03);
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h8a);
        for (k = 0; k < 99 && sda_oe !== 1'b1; k++) @(posedge core_clk);
        lim(k, 99);
        chk({sda_oe, scl_oe, 6'h00}, 8'h80);
        // Start passes two line flops and the detector before busy shows
        repeat (4) @(posedge core_clk);
        rd(i2cmm_pkg::OFS_FLAG, 8'h43);
        repeat (100) @(posedge core_clk);
        acc(1'b1, i2cmm_pkg::OFS_SHIFT, 8'ha0);
        for (k = 0; k < 3000 && bus_event_irq !== 1'b1; k++) @(posedge core_clk);
        lim(k, 3000);
        chk({7'h00, bus_event_irq}, 8'h01);
        acc(1'b0, i2cmm_pkg::OFS_STATUS, 8'h00);
        chk({q[7], q[2], 6'h00}, 8'hc0);
        // Stop request with the stop event enabled
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h99);
        for (k = 0; k < 50; k++) begin
            acc(1'b0, i2cmm_pkg::OFS_FLAG, 8'h00);
            if (q[6] === 1'b0) break;
        end
        lim(k, 50);
        chk({q[6], scl_oe, sda_oe, 5'h00}, 8'h00);
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h00);
        rd(i2cmm_pkg::OFS_STATUS, 8'h00);
        acc(1'b1, i2cmm_pkg::OFS_FLAG, 8'h01);
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h80);
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h82);
        rd(i2cmm_pkg::OFS_FLAG, 8'hc1);
        chk({7'h00, sda_oe}, 8'h00);
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h00);
        rd(i2cmm_pkg::OFS_FLAG, 8'h01);
        // Far-side master addresses this block as a slave
        acc(1'b1, i2cmm_pkg::OFS_CTRL, 8'h80);
        bb(1'b1, 1'b0);
        for (k = 7; k >= 0; k--) begin
            bb(1'b0, SLV_BYTE[k]);
            bb(1'b1, SLV_BYTE[k]);
        end
        ext_scl_pull <= 1'b1;
        for (k = 0; k < 20 && bus_event_irq !== 1'b1; k++) @(posedge core_clk);
        lim(k, 20);
        chk({7'h00, bus_event_irq}, 8'h01);
        chk({7'h00, scl_oe}, 8'h01);
        rd(i2cmm_pkg::OFS_STATUS, 8'h12);
        conclude();
    end
endmodule : i2c_multimaster_controller_bench

// ===== verif/i2cmm_peer.sv
// Bus model: pull-ups on both lines and one slave that acknowledges the first byte after each start
`timescale 1ns/1ns
module i2cmm_peer (
    // Open-drain pulls from the controller
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Pulls from a far-side master driven by the bench
    input wire logic ext_scl_pull,
    input wire logic ext_sda_pull,
    // Resolved line levels
    output logic scl,
    output logic sda
);
    logic ack_drv = 1'b0;
    int falls = 0;
    assign scl = ~(scl_oe | ext_scl_pull);
    assign sda = ~(sda_oe | ack_drv | ext_sda_pull);
    // Start restarts the bit count
    always @(negedge sda) if (scl) falls = 0;
    always @(negedge scl) begin
        falls = falls + 1;
        ack_drv = (falls == 9);
    end
endmodule : i2cmm_peer
